// >>> inc/edc_cfg.svh
`ifndef EDC_CFG_SVH
`define EDC_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define EDC_OFF_CFG        12'h000
`define EDC_OFF_STATUS     12'h004
`define EDC_OFF_MASK       12'h008
`define EDC_OFF_STATE      12'h00c
`define EDC_OFF_TOF1       12'h010
`define EDC_OFF_TOF2       12'h014

// ----------------------------------------
// config field positions
// ----------------------------------------
`define EDC_F_REV_DEB      0
`define EDC_F_Q_SEL        2
`define EDC_F_AUTO_Q       4
`define EDC_F_AUTO_EDEB    5
`define EDC_F_PULLUP       6
`define EDC_F_FAST_SLOPE   7
`define EDC_F_ADV          8
`define EDC_F_FIRST_RX     9
`define EDC_F_SKIP_FIRST   10
`define EDC_F_DIAG         11
`define EDC_F_REV_THR      12
`define EDC_F_REV_TOUT     16

// ----------------------------------------
// status bit positions
// ----------------------------------------
`define EDC_S_NOISE        0
`define EDC_S_REV_END      1
`define EDC_S_ECHO         2
`define EDC_S_DONE         3
`define EDC_S_REV_TOUT     5
`define EDC_STATUS_MASK    32'h0000002f

// ----------------------------------------
// reset values
// ----------------------------------------
`define EDC_RST_REV_DEB    2'h1
`define EDC_RST_Q_SEL      2'h1
`define EDC_RST_AUTO_Q     1'h0
`define EDC_RST_AUTO_EDEB  1'h0
`define EDC_RST_PULLUP     1'h1
`define EDC_RST_FAST_SLOPE 1'h0
`define EDC_RST_ADV        1'h0
`define EDC_RST_FIRST_RX   1'h0
`define EDC_RST_SKIP_FIRST 1'h1
`define EDC_RST_DIAG       1'h1
`define EDC_RST_REV_THR    1'h0
`define EDC_RST_REV_TOUT   6'h27

// ----------------------------------------
// timing
// ----------------------------------------
`define EDC_CLK_PERIOD_NS  50
`define EDC_CYC(ns)        (((ns) + `EDC_CLK_PERIOD_NS - 1) / `EDC_CLK_PERIOD_NS)
`define EDC_DEB60_NS       60000
`define EDC_DEB100_NS      100000
`define EDC_DEB140_NS      140000
`define EDC_DEB180_NS      180000
`define EDC_DEB200_NS      200000
`define EDC_TOUT_LSB_NS    51200
`define EDC_QSW_NS         14800000
`define EDC_DEB60_CYC      `EDC_CYC(`EDC_DEB60_NS)
`define EDC_DEB100_CYC     `EDC_CYC(`EDC_DEB100_NS)
`define EDC_DEB140_CYC     `EDC_CYC(`EDC_DEB140_NS)
`define EDC_DEB180_CYC     `EDC_CYC(`EDC_DEB180_NS)
`define EDC_DEB200_CYC     `EDC_CYC(`EDC_DEB200_NS)
`define EDC_TOUT_LSB_CYC   `EDC_CYC(`EDC_TOUT_LSB_NS)
`define EDC_QSW_CYC        `EDC_CYC(`EDC_QSW_NS)

// ----------------------------------------
// q by pulse count, reverb threshold ratio
// ----------------------------------------
`define EDC_PULSES_Q10     12
`define EDC_PULSES_Q20     24
`define EDC_THR75_NUM      3
`define EDC_THR75_SHR      2
`define EDC_THR50_SHR      1

`endif

// >>> inc/edc_pkg.sv
package edc_pkg;

    typedef enum logic [1:0] {
        EDC_IDLE,
        EDC_TX,
        EDC_REVERB,
        EDC_ECHO
    } edc_state_t;

    typedef enum logic [1:0] {
        EDC_Q5,
        EDC_Q10,
        EDC_Q20
    } edc_q_t;

endpackage

// >>> rtl/edc_top.sv
// Function
// - reverb end debounce: 60, 100, 140 or 180 us by 2-bit code, default 100.
// - q code 0,1,2 gives 5,10,20; code 3 follows transmit pulse count.
// - auto q switches q 14.8 ms after start per q code table.
// - auto q off: q fixed by q code for whole measurement.
// - echo debounce 60 us; with auto debounce becomes 200 us after 14.8 ms.
// - line pull-up connected only while pull-up enable, as taken while idle, is one.
// - line slope standard 60 us when bit zero, fast 20 us when one.
// - standard line protocols when advanced enable zero, advanced protocol when one.
// - first receive uses first curve, or fixed noise threshold with noise flag carried.
// - reverb time-out from transmit end equals field times 51.2 us, default 39.
// - echo detection waits for reverb end or reverb time-out.
// - status bit 5 set when reverb phase ends by time-out.
// - advanced indirect: skip bit reports echoes 2,3 instead of 1,2.
// - diagnostic reporting on line while diagnostic enable or advanced enable is one.
// - advanced protocol always reports diagnostics.
// - reverb threshold 75% of full scale, or 50% when bit set.
`timescale 1ns/1ps
`default_nettype none
`include "edc_cfg.svh"

module edc_top
    import edc_pkg::*;
#(
    parameter int QSW_CYCLES = `EDC_QSW_CYC,
    parameter int MAG_W      = 8,
    parameter int TIME_W     = 20,
    parameter int PULSE_W    = 5
) (
    input  wire logic               ref_clk_i,
    input  wire logic               reset_i,
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic [11:0]        paddr_i,
    input  wire logic [31:0]        pwdata_i,
    input  wire logic [3:0]         pstrb_i,
    output logic      [31:0]        prdata_o,
    output logic                    pready_o,
    output logic                    pslverr_o,
    input  wire logic               meas_start_i,
    input  wire logic               meas_stop_i,
    input  wire logic               first_rx_cmd_i,
    input  wire logic               indirect_i,
    input  wire logic [PULSE_W-1:0] tx_pulses_i,
    input  wire logic               tx_end_i,
    input  wire logic [MAG_W-1:0]   magnitude_i,
    input  wire logic               echo_raw_i,
    input  wire logic               noise_i,
    output logic                    line_pullup_en_o,
    output logic                    line_fast_slope_o,
    output logic                    advanced_protocol_o,
    output logic                    diag_report_o,
    output logic                    fixed_noise_threshold_o,
    output logic                    noise_flag_o,
    output logic                    echo_detect_en_o,
    output logic                    echo_debounce_long_o,
    output logic [1:0]              q_factor_o,
    output logic [TIME_W-1:0]       tof1_o,
    output logic [TIME_W-1:0]       tof2_o,
    output logic                    irq_o
);

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic [11:0] rev_deb_cycles(input logic [1:0] sel);
        case (sel)
            2'h0:    rev_deb_cycles = 12'(`EDC_DEB60_CYC);
            2'h1:    rev_deb_cycles = 12'(`EDC_DEB100_CYC);
            2'h2:    rev_deb_cycles = 12'(`EDC_DEB140_CYC);
            default: rev_deb_cycles = 12'(`EDC_DEB180_CYC);
        endcase
    endfunction

    function automatic edc_q_t q_by_pulses(input logic [PULSE_W-1:0] n);
        if (n < PULSE_W'(`EDC_PULSES_Q10)) begin
            q_by_pulses = EDC_Q5;
        end else if (n < PULSE_W'(`EDC_PULSES_Q20)) begin
            q_by_pulses = EDC_Q10;
        end else begin
            q_by_pulses = EDC_Q20;
        end
    endfunction

    function automatic edc_q_t q_pick(input logic [1:0] sel, input logic auto_q,
                                      input logic late, input logic [PULSE_W-1:0] n);
        case (sel)
            2'h0:    q_pick = (auto_q && late) ? EDC_Q10 : EDC_Q5;
            2'h1:    q_pick = auto_q ? (late ? EDC_Q20 : EDC_Q5) : EDC_Q10;
            2'h2:    q_pick = (auto_q && !late) ? EDC_Q10 : EDC_Q20;
            default: q_pick = (auto_q && !late) ? EDC_Q5 : q_by_pulses(n);
        endcase
    endfunction

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    logic [31:0] cfg_q;
    logic [31:0] status_q;
    logic [31:0] mask_q;
    logic [31:0] rdata_d;
    logic        hit_d;
    logic        wr_stb;
    logic [31:0] bmask;
    logic [31:0] status_set;
    edc_state_t  state_q;
    edc_q_t      q_now;

    assign wr_stb = psel_i && penable_i && pwrite_i && pready_o;

    generate
        for (genvar b = 0; b < 4; b++) begin : g_lane
            assign bmask[8*b +: 8] = {8{pstrb_i[b]}};
        end
    endgenerate

    always_comb begin
        hit_d   = 1'b1;
        rdata_d = 32'h0;
        case (paddr_i)
            `EDC_OFF_CFG:    rdata_d = cfg_q;
            `EDC_OFF_STATUS: rdata_d = status_q;
            `EDC_OFF_MASK:   rdata_d = mask_q;
            `EDC_OFF_STATE:  rdata_d = {26'h0, 2'(q_now), 2'(state_q), echo_detect_en_o, echo_debounce_long_o};
            `EDC_OFF_TOF1:   rdata_d = 32'(tof1_o);
            `EDC_OFF_TOF2:   rdata_d = 32'(tof2_o);
            default:         hit_d = 1'b0;
        endcase
    end

    // zero wait states: ready rises in the access cycle
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0;
        end else begin
            pready_o  <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !hit_d;
            prdata_o  <= (psel_i && !penable_i && !pwrite_i && hit_d) ? rdata_d : 32'h0;
        end
    end

    // ----------------------------------------
    // configuration and mask registers
    // ----------------------------------------
    localparam logic [31:0] CFG_RST = (32'(`EDC_RST_REV_DEB) << `EDC_F_REV_DEB)
        | (32'(`EDC_RST_Q_SEL) << `EDC_F_Q_SEL) | (32'(`EDC_RST_AUTO_Q) << `EDC_F_AUTO_Q)
        | (32'(`EDC_RST_AUTO_EDEB) << `EDC_F_AUTO_EDEB) | (32'(`EDC_RST_PULLUP) << `EDC_F_PULLUP)
        | (32'(`EDC_RST_FAST_SLOPE) << `EDC_F_FAST_SLOPE) | (32'(`EDC_RST_ADV) << `EDC_F_ADV)
        | (32'(`EDC_RST_FIRST_RX) << `EDC_F_FIRST_RX) | (32'(`EDC_RST_SKIP_FIRST) << `EDC_F_SKIP_FIRST)
        | (32'(`EDC_RST_DIAG) << `EDC_F_DIAG) | (32'(`EDC_RST_REV_THR) << `EDC_F_REV_THR)
        | (32'(`EDC_RST_REV_TOUT) << `EDC_F_REV_TOUT);
    localparam logic [31:0] CFG_MASK = 32'h003f1fff;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            cfg_q  <= CFG_RST;
            mask_q <= 32'h0;
        end else if (wr_stb && paddr_i == `EDC_OFF_CFG) begin
            cfg_q <= ((cfg_q & ~bmask) | (pwdata_i & bmask)) & CFG_MASK;
        end else if (wr_stb && paddr_i == `EDC_OFF_MASK) begin
            mask_q <= ((mask_q & ~bmask) | (pwdata_i & bmask)) & `EDC_STATUS_MASK;
        end
    end

    // ----------------------------------------
    // shadow copy, frozen during a measurement
    // ----------------------------------------
    logic [31:0] sh_q;
    logic        active;
    logic        load_sh;

    assign active  = state_q != EDC_IDLE;
    assign load_sh = !active;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            sh_q <= CFG_RST;
        end else if (load_sh) begin
            sh_q <= cfg_q;
        end
    end

    // line controls load from cfg_q together with the shadow so they never move mid-frame
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            line_pullup_en_o    <= `EDC_RST_PULLUP;
            line_fast_slope_o   <= `EDC_RST_FAST_SLOPE;
            advanced_protocol_o <= `EDC_RST_ADV;
            diag_report_o       <= `EDC_RST_DIAG;
        end else if (load_sh) begin
            line_pullup_en_o    <= cfg_q[`EDC_F_PULLUP];
            line_fast_slope_o   <= cfg_q[`EDC_F_FAST_SLOPE];
            advanced_protocol_o <= cfg_q[`EDC_F_ADV];
            diag_report_o       <= cfg_q[`EDC_F_DIAG] | cfg_q[`EDC_F_ADV];
        end
    end

    // ----------------------------------------
    // measurement sequencer
    // ----------------------------------------
    logic [TIME_W-1:0] time_q;
    logic [15:0]       rev_cnt_q;
    logic [11:0]       rdeb_q;
    logic [11:0]       edeb_q;
    logic [1:0]        echo_cnt_q;
    logic              echo_seen_q;
    logic              late;
    logic              below;
    logic              rev_tout;
    logic              rev_done;
    logic              echo_ev;
    logic [MAG_W-1:0]  rev_thr;
    logic [15:0]       tout_lim;
    logic [11:0]       edeb_lim;
    logic              first_fixed_q;
    logic              noise_carry_q;

    localparam logic [MAG_W-1:0] FULL = '1;
    localparam logic [MAG_W+1:0] FULL75 = (MAG_W+2)'(`EDC_THR75_NUM) * {2'b00, FULL};

    assign late     = time_q >= TIME_W'(QSW_CYCLES);
    assign rev_thr  = sh_q[`EDC_F_REV_THR] ? (FULL >> `EDC_THR50_SHR)
                                           : MAG_W'(FULL75 >> `EDC_THR75_SHR);
    assign below    = magnitude_i < rev_thr;
    assign tout_lim = 16'(sh_q[`EDC_F_REV_TOUT +: 6] * 16'(`EDC_TOUT_LSB_CYC));
    assign rev_tout = (state_q == EDC_REVERB) && rev_cnt_q >= tout_lim;
    assign rev_done = (state_q == EDC_REVERB) && below
                   && rdeb_q == rev_deb_cycles(sh_q[`EDC_F_REV_DEB +: 2]) - 12'h1;
    assign edeb_lim = echo_debounce_long_o ? 12'(`EDC_DEB200_CYC) : 12'(`EDC_DEB60_CYC);
    assign echo_ev  = (state_q == EDC_ECHO) && echo_raw_i && !echo_seen_q
                   && edeb_q == edeb_lim - 12'h1;
    assign q_now    = q_pick(sh_q[`EDC_F_Q_SEL +: 2], sh_q[`EDC_F_AUTO_Q], late, tx_pulses_i);

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_q <= EDC_IDLE;
        end else if (meas_stop_i) begin
            state_q <= EDC_IDLE;
        end else begin
            case (state_q)
                EDC_IDLE:   if (meas_start_i) state_q <= EDC_TX;
                EDC_TX:     if (tx_end_i) state_q <= EDC_REVERB;
                EDC_REVERB: if (rev_done || rev_tout) state_q <= EDC_ECHO;
                EDC_ECHO:   state_q <= EDC_ECHO;
                default:    state_q <= EDC_IDLE;
            endcase
        end
    end

    // saturating time since start drives the 14.8 ms switch and tof stamps
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || !active) begin
            time_q <= '0;
        end else if (time_q != '1) begin
            time_q <= time_q + TIME_W'(1);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i || state_q != EDC_REVERB) begin
            rev_cnt_q <= 16'h0;
            rdeb_q    <= 12'h0;
        end else begin
            rev_cnt_q <= rev_cnt_q + 16'h1;
            rdeb_q    <= below ? rdeb_q + 12'h1 : 12'h0;
        end
    end

    // one echo per high period; chattering shorter than the debounce is dropped
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || state_q != EDC_ECHO || !echo_raw_i) begin
            edeb_q      <= 12'h0;
            echo_seen_q <= 1'b0;
        end else if (echo_ev) begin
            echo_seen_q <= 1'b1;
        end else if (!echo_seen_q) begin
            edeb_q <= edeb_q + 12'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            echo_detect_en_o     <= 1'b0;
            echo_debounce_long_o <= 1'b0;
            q_factor_o           <= 2'(EDC_Q10);
        end else begin
            echo_detect_en_o     <= (state_q == EDC_REVERB && (rev_done || rev_tout))
                                 || (state_q == EDC_ECHO && !meas_stop_i);
            echo_debounce_long_o <= active && sh_q[`EDC_F_AUTO_EDEB] && late;
            q_factor_o           <= 2'(q_now);
        end
    end

    // ----------------------------------------
    // time of flight capture
    // ----------------------------------------
    logic skip_one;

    assign skip_one = sh_q[`EDC_F_SKIP_FIRST] && sh_q[`EDC_F_ADV] && indirect_i;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i || (state_q == EDC_IDLE && meas_start_i)) begin
            echo_cnt_q <= 2'h0;
            tof1_o     <= '0;
            tof2_o     <= '0;
        end else if (echo_ev && echo_cnt_q != 2'h3) begin
            echo_cnt_q <= echo_cnt_q + 2'h1;
            if (echo_cnt_q == 2'(skip_one)) begin
                tof1_o <= time_q;
            end
            if (echo_cnt_q == 2'(skip_one) + 2'h1) begin
                tof2_o <= time_q;
            end
        end
    end

    // ----------------------------------------
    // first receive threshold and noise carry
    // ----------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            first_fixed_q           <= 1'b0;
            fixed_noise_threshold_o <= 1'b0;
            noise_carry_q           <= 1'b0;
            noise_flag_o            <= 1'b0;
        end else if (state_q == EDC_IDLE && meas_start_i) begin
            first_fixed_q           <= first_rx_cmd_i && cfg_q[`EDC_F_FIRST_RX];
            fixed_noise_threshold_o <= first_rx_cmd_i && cfg_q[`EDC_F_FIRST_RX];
            noise_flag_o            <= noise_carry_q;
            noise_carry_q           <= 1'b0;
        end else if (active && noise_i) begin
            noise_flag_o  <= 1'b1;
            noise_carry_q <= noise_carry_q | first_fixed_q;
        end
    end

    // ----------------------------------------
    // status and interrupt
    // ----------------------------------------
    always_comb begin
        status_set                   = 32'h0;
        status_set[`EDC_S_NOISE]     = active && noise_i;
        status_set[`EDC_S_REV_END]   = rev_done;
        status_set[`EDC_S_ECHO]      = echo_ev;
        status_set[`EDC_S_DONE]      = active && meas_stop_i;
        status_set[`EDC_S_REV_TOUT]  = rev_tout && !rev_done;
    end

    // a new event wins over a same-cycle clear
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            status_q <= 32'h0;
        end else if (wr_stb && paddr_i == `EDC_OFF_STATUS) begin
            status_q <= (status_q & ~(pwdata_i & bmask)) | status_set;
        end else begin
            status_q <= status_q | status_set;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |((status_q | status_set) & mask_q);
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_REV_DEBOUNCE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (state_q == EDC_REVERB && !meas_stop_i && sh_q[1:0] == 2'h0 && rdeb_q == 12'd1199 && below)
        |=> state_q == EDC_ECHO) else $error("reverb end not taken after 60 us");
    AST_Q_SEL_FIXED: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (!sh_q[`EDC_F_AUTO_Q] && sh_q[3:2] == 2'h2) |=> q_factor_o == 2'(EDC_Q20))
        else $error("q code 2 not q 20");
    AST_Q_SWITCH: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (active && sh_q[`EDC_F_AUTO_Q] && sh_q[3:2] == 2'h0 && time_q == TIME_W'(QSW_CYCLES - 1))
        |=> q_factor_o == 2'(EDC_Q5) ##1 q_factor_o == 2'(EDC_Q10)) else $error("auto q switch time wrong");
    AST_Q_STABLE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (active && !sh_q[`EDC_F_AUTO_Q] && sh_q[3:2] != 2'h3) ##1 active |=> $stable(q_factor_o))
        else $error("fixed q moved");
    AST_ECHO_DEB: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (active && !meas_stop_i && sh_q[`EDC_F_AUTO_EDEB] && time_q == TIME_W'(QSW_CYCLES))
        |=> echo_debounce_long_o) else $error("echo debounce not lengthened");
    AST_PULLUP: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !active |=> line_pullup_en_o == $past(cfg_q[`EDC_F_PULLUP])) else $error("pull-up mismatch");
    AST_FROZEN: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        active ##1 active |-> $stable(line_fast_slope_o) && $stable(sh_q)) else $error("config moved mid-frame");
    AST_NO_EARLY_ECHO: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        state_q != EDC_ECHO |-> !echo_ev ##1 !(state_q == EDC_TX && echo_detect_en_o))
        else $error("echo before reverb end");
    AST_TOUT_FLAG: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (rev_tout && !rev_done) |=> status_q[`EDC_S_REV_TOUT]) else $error("time-out flag missing");
    AST_DIAG_ADV: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        advanced_protocol_o |-> diag_report_o) else $error("diagnostic off under advanced protocol");

endmodule
`default_nettype wire

// >>> dv/edc_fe_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// front end: transmit burst and echo magnitude
// ----------------------------------------
module edc_fe_model #(
    parameter int TX_LEN = 20
) (
    input  wire logic       ref_clk_i,
    input  wire logic       meas_start_i,
    input  wire logic       loud_i,
    output logic            tx_end_o,
    output logic [7:0]      magnitude_o
);
    int cnt_q = 0;
    initial tx_end_o = 1'b0;
    // full scale while ringing, so only the time-out can end it
    // quiet level sits between the 50% and 75% thresholds
    assign magnitude_o = loud_i ? 8'hff : 8'ha0;
    always @(posedge ref_clk_i) begin
        tx_end_o <= (cnt_q == 1);
        if (meas_start_i) begin
            cnt_q <= TX_LEN;
        end else if (cnt_q > 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
endmodule
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, start = 0, stop = 0, loud = 0, noise = 0, frx = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, txe, pup, slope, adv, diag, fnt, nfl, een, dlong, irq, perr;
    logic [1:0]  q;
    logic [7:0]  mag;
    int          num_errors = 0, comparisons = 0;
    logic [11:0] ra [5] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h020};
    logic [31:0] re [5] = '{32'h00270c45, 32'h0, 32'h0, 32'h10, 32'h0};
    logic        rerr [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

    edc_top #(.QSW_CYCLES(200)) dut_u (.ref_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .meas_start_i(start), .meas_stop_i(stop),
        .first_rx_cmd_i(frx), .indirect_i(1'b0), .tx_pulses_i(5'h0), .tx_end_i(txe), .magnitude_i(mag),
        .echo_raw_i(1'b0), .noise_i(noise), .line_pullup_en_o(pup), .line_fast_slope_o(slope),
        .advanced_protocol_o(adv), .diag_report_o(diag), .fixed_noise_threshold_o(fnt),
        .noise_flag_o(nfl), .echo_detect_en_o(een), .echo_debounce_long_o(dlong), .q_factor_o(q),
        .tof1_o(), .tof2_o(), .irq_o(irq));
    edc_fe_model fe_u (.ref_clk_i(clk), .meas_start_i(start), .loud_i(loud), .tx_end_o(txe),
        .magnitude_o(mag));

    initial forever #25 clk = ~clk;
    initial begin
        #2000000;
        num_errors++;
        complete_run();
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // ready is looked at after the edge has settled, so the next edge is the access edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        #1;
        while (pready !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        rd = prdata;
        perr = pslverr;
        @(posedge clk);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse_start(input logic s);
        @(posedge clk);
        if (s) start <= 1'b1;
        else stop <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        stop <= 1'b0;
    endtask
    task automatic wait_txe();
        while (txe !== 1'b1) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        cyc(10);
        chk({pup, slope, adv, diag, q}, {4'b1001, 2'h1});
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, ra[i], 32'h0);
            chk(rd, re[i]);
            chk(perr, rerr[i]);
        end
        $display("test register reset values done");
        // time-out ending, advanced protocol forcing diagnostics
        apb(1'b1, 12'h000, 32'h00010189);
        apb(1'b1, 12'h008, 32'h20);
        cyc(2);
        chk({pup, slope, adv, diag}, 4'b0111);
        loud <= 1'b1;
        pulse_start(1'b1);
        noise <= 1'b1;
        @(posedge clk);
        noise <= 1'b0;
        wait_txe();
        cyc(1025);
        chk(een, 1'b0);
        cyc(1);
        chk(een, 1'b1);
        chk(irq, 1'b1);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd & 32'h20, 32'h20);
        apb(1'b1, 12'h004, 32'h20);
        cyc(2);
        chk(irq, 1'b0);
        pulse_start(1'b0);
        $display("test reverb time-out done");
        // auto q and auto debounce, quiet reverb, late config write, noise carry
        apb(1'b1, 12'h000, 32'h003f0238);
        loud <= 1'b0;
        frx <= 1'b1;
        cyc(2);
        chk({adv, diag}, 2'b00);
        pulse_start(1'b1);
        cyc(3);
        chk({q, dlong, fnt}, {2'h1, 1'b0, 1'b1});
        @(posedge clk);
        noise <= 1'b1;
        @(posedge clk);
        noise <= 1'b0;
        apb(1'b1, 12'h000, 32'h003f0278);
        cyc(2);
        chk(pup, 1'b0);
        cyc(250);
        chk({q, dlong}, {2'h2, 1'b1});
        pulse_start(1'b0);
        frx <= 1'b0;
        pulse_start(1'b1);
        wait_txe();
        chk({fnt, nfl}, 2'b01);
        cyc(1200);
        chk(een, 1'b0);
        cyc(1);
        chk(een, 1'b1);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd & 32'h20, 32'h0);
        pulse_start(1'b0);
        cyc(3);
        chk(pup, 1'b1);
        $display("test auto switching done");
        complete_run();
    end
endmodule
`default_nettype wire
